// file: shared/pis_pkg.sv
// constants and types for the process i/o bus synchronizer
`default_nettype none
package pis_pkg;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_NS   = 50;
  localparam int TICK_NS  = 8000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

  // ------------------------------------------------------------------
  // operand layout
  // ------------------------------------------------------------------
  localparam int OP_W      = 24;
  localparam int DIG_MUX_W = 10;
  localparam int VLV_MUX_W = 9;
  localparam int CMD_LSB   = 11;
  localparam int CMD_W     = 4;
  localparam int SKIP_BIT  = 15;
  localparam int DEV_LSB   = 16;
  localparam int DEV_W     = 8;
  localparam int MCLR_BIT  = 23;

  // ------------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------------
  localparam logic [3:0] CMD_RD_DATA  = 4'h1;
  localparam logic [3:0] CMD_WR_DATA  = 4'h2;
  localparam logic [3:0] CMD_RD_STAT  = 4'h3;
  localparam logic [3:0] CMD_RD_CLR   = 4'h4;
  localparam logic [3:0] CMD_WR_STAT  = 4'h5;
  localparam logic [3:0] CMD_RD_LEVEL = 4'h6;

  // ------------------------------------------------------------------
  // multiplexer map and valve data layout
  // ------------------------------------------------------------------
  localparam logic [4:0] MUX_CNT_PAGE = 5'h00;
  localparam logic [4:0] MUX_AO_PAGE  = 5'h01;
  localparam logic [9:0] MUX_PI_ADDR  = 10'h040;
  localparam int VD_CNT_W  = 7;
  localparam int VD_DIR    = 7;
  localparam logic [7:0] VD_FULL = 8'h80;
  localparam int CNT_LO_W  = 8;
  localparam int CNT_HI_W  = 14;
  localparam int AO_W      = 10;

  // ------------------------------------------------------------------
  // status bits
  // ------------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_VIOL = 1;

  // ------------------------------------------------------------------
  // apb map and reset values
  // ------------------------------------------------------------------
  localparam logic [11:0] ADDR_DEVCFG = 12'h000;
  localparam logic [11:0] ADDR_LEVEL  = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_VALVE  = 12'h00C;
  localparam logic [7:0] RST_CRIT    = 8'h01;
  localparam logic [7:0] RST_NONCRIT = 8'h02;
  localparam logic [7:0] RST_VALVE   = 8'h03;
  localparam logic [7:0] RST_LEVEL   = 8'h04;
  localparam logic [4:0] RST_INTBIT  = 5'h00;

  typedef enum logic [3:0] {
    PIS_IDLE = 4'b0001,
    PIS_CMD  = 4'b0010,
    PIS_WAIT = 4'b0100,
    PIS_DONE = 4'b1000
  } pis_state_type;
endpackage
`default_nettype wire

// file: rtl/pis_sync.sv
// process i/o bus synchronizer: counters, analog holds, valve pulser
//
// The implementer's own choices: register access over APB and the register offsets.
`default_nettype none
// How it works
// RQ1 - one independent counter register per pulse input, up to thirty-two inputs
// RQ2 - low-rate counters wrap in eight bits, fine for 100 pulses per second
// RQ3 - high-rate counters hold fourteen bits, fine for 15,000 pulses per second
// RQ4 - critical read-data returns counter or interrupt latch, then resets it
// RQ5 - each analog output keeps its written ten-bit value until rewritten
// RQ6 - digital multiplexer address bits 0-9 pick group, counter or analog output
// RQ7 - valve multiplexer address bits 0-8 pick one of 512 valve channels
// RQ8 - valve pulse lasts loaded count times eight microseconds
// RQ9 - only one valve pulse runs at a time across all channels
// RQ10 - valve write is acknowledged, then the pulse is timed without the bus
// RQ11 - each valve channel has increase and decrease outputs chosen by data
// RQ12 - operand holds mux address, command to bit 14, skip 15, device 16-23
// RQ13 - noncritical address reads only; critical writes and resets; valve does all
// RQ14 - level status read drives the assigned interrupt bit when levels match
// RQ15 - read data puts one 24-bit word on the bus
// RQ16 - write data captures one 24-bit word from the bus
// RQ17 - read status returns a word of device and synchronizer conditions
// RQ18 - read status and clear returns status then clears it
// RQ19 - write status with bit 23 low loads status bits from data
// RQ20 - write status with bit 23 high performs a master clear
// RQ21 - processor issues a command and waits for the command response
// RQ22 - data phase: drive or capture data lines, then give a second response
// RQ23 - processor times each exchange and aborts after about twelve microseconds
// RQ24 - counters wrap on overflow; a pulse during read-and-reset is kept
// RQ25 - valve data holds a 1 to 128 width count and a direction bit
module pis_sync #(
  parameter int          NCNT    = 32,
  parameter int          NAO     = 32,
  parameter logic [31:0] HI_MASK = 32'h0000FFFF
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                cmd_req,
  input  wire logic [23:0]         cmd_word,
  output logic                     cmd_ack,
  input  wire logic                xfer_req,
  input  wire logic [23:0]         bus_data_in,
  output logic      [23:0]         bus_data_out,
  output logic                     xfer_ack,
  input  wire logic [NCNT-1:0]     pulse_in,
  input  wire logic [23:0]         proc_int_in,
  input  wire logic [23:0]         dig_in,
  output logic      [9:0]          dig_addr,
  output logic      [23:0]         dig_out,
  output logic                     dig_out_stb,
  output logic      [NAO*10-1:0]   analog_out,
  output logic      [8:0]          valve_chan,
  output logic                     valve_inc,
  output logic                     valve_dec
);

  typedef struct packed {
    pis_pkg::pis_state_type        fsm;
    logic [23:0]                   cmd;
    logic [23:0]                   rdata;
    logic                          cmd_ack;
    logic                          xfer_ack;
    logic [NCNT-1:0]               prev;
    logic [NCNT-1:0][13:0]         cnt;
    logic [23:0]                   pi;
    logic [NAO-1:0][9:0]           ao;
    logic [23:0]                   dig_out;
    logic [9:0]                    dig_addr;
    logic                          dig_stb;
    logic [23:0]                   status;
    logic [7:0]                    crit;
    logic [7:0]                    noncrit;
    logic [7:0]                    valve;
    logic [7:0]                    level;
    logic [4:0]                    intbit;
    logic                          v_busy;
    logic                          v_dir;
    logic [8:0]                    v_chan;
    logic [7:0]                    v_left;
    logic [7:0]                    v_div;
    logic                          v_inc;
    logic                          v_dec;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
  } pis_state_reg_type;

  pis_state_reg_type r_reg;
  pis_state_reg_type r_next;

  localparam int CNT_LO_W_M1 = pis_pkg::CNT_LO_W - 1;

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign prdata       = r_reg.prdata;
  assign pready       = r_reg.pready;
  assign pslverr      = r_reg.pslverr;
  assign cmd_ack      = r_reg.cmd_ack;
  assign xfer_ack     = r_reg.xfer_ack;
  assign bus_data_out = r_reg.rdata;
  assign dig_addr     = r_reg.dig_addr;
  assign dig_out      = r_reg.dig_out;
  assign dig_out_stb  = r_reg.dig_stb;
  assign valve_chan   = r_reg.v_chan;
  assign valve_inc    = r_reg.v_inc;
  assign valve_dec    = r_reg.v_dec;

  for (genvar g = 0; g < NAO; g++) begin : g_ao
    assign analog_out[g*10 +: 10] = r_reg.ao[g]; // RQ5
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [NCNT-1:0] edge_v;
    logic [13:0]     sum;
    logic [7:0]      dev;
    logic [3:0]      op;
    logic [9:0]      mux;
    logic [23:0]     stat_word;
    logic            ok;
    logic            is_crit;
    logic            is_valve;
    logic            hit;
    edge_v    = '0;
    sum       = '0;
    dev       = '0;
    op        = '0;
    mux       = '0;
    ok        = 1'b0;
    hit       = 1'b0;
    is_crit   = 1'b0;
    is_valve  = 1'b0;
    r_next    = r_reg;
    r_next.dig_stb = 1'b0;
    stat_word = {r_reg.status[23:1], r_reg.v_busy}; // RQ17

    // pulse counting on rising edges
    edge_v      = pulse_in & ~r_reg.prev;
    r_next.prev = pulse_in;
    for (int i = 0; i < NCNT; i++) begin
      sum = r_reg.cnt[i] + {13'h0000, edge_v[i]}; // RQ1
      r_next.cnt[i] = HI_MASK[i] ? sum : {6'h00, sum[CNT_LO_W_M1:0]}; // RQ2 RQ3 RQ24
    end
    r_next.pi = r_reg.pi | proc_int_in;

    // valve pulse timing, one tick per eight microseconds
    if (r_reg.v_busy) begin // RQ10
      if (r_reg.v_div == pis_pkg::TICK_LAST) begin
        r_next.v_div = 8'h00;
        if (r_reg.v_left == 8'h01) begin
          r_next.v_busy = 1'b0; // RQ8
        end
        r_next.v_left = r_reg.v_left - 8'h01;
      end else begin
        r_next.v_div = r_reg.v_div + 8'h01;
      end
    end

    // programmed_io_bus handshake
    dev      = r_reg.cmd[pis_pkg::DEV_LSB +: pis_pkg::DEV_W]; // RQ12
    op       = r_reg.cmd[pis_pkg::CMD_LSB +: pis_pkg::CMD_W];
    mux      = r_reg.cmd[pis_pkg::DIG_MUX_W-1:0]; // RQ6
    is_crit  = (dev == r_reg.crit);
    is_valve = (dev == r_reg.valve);
    unique case (r_reg.fsm)
      pis_pkg::PIS_IDLE: begin
        if (cmd_req) begin // RQ21
          if (cmd_word[14:11] == pis_pkg::CMD_RD_LEVEL) begin
            ok = (cmd_word[23:16] == r_reg.level);
          end else if (cmd_word[14:11] == 4'h0 || cmd_word[14:11] > pis_pkg::CMD_WR_STAT) begin
            ok = 1'b0;
          end else if (cmd_word[23:16] == r_reg.valve || cmd_word[23:16] == r_reg.crit) begin
            ok = 1'b1; // RQ13
          end else if (cmd_word[23:16] == r_reg.noncrit) begin
            ok = (cmd_word[14:11] == pis_pkg::CMD_RD_DATA)
               || (cmd_word[14:11] == pis_pkg::CMD_RD_STAT); // RQ13
            if (!ok) begin
              r_next.status[pis_pkg::ST_VIOL] = 1'b1;
            end
          end
          if (ok) begin
            r_next.cmd     = cmd_word;
            r_next.cmd_ack = 1'b1; // RQ21
            r_next.fsm     = pis_pkg::PIS_CMD;
          end
        end
      end
      pis_pkg::PIS_CMD: begin
        if (!cmd_req) begin
          r_next.cmd_ack = 1'b0;
          r_next.fsm     = pis_pkg::PIS_WAIT;
        end
      end
      pis_pkg::PIS_WAIT: begin
        if (xfer_req && !(is_valve && op == pis_pkg::CMD_WR_DATA && r_reg.v_busy)) begin // RQ9
          r_next.xfer_ack = 1'b1; // RQ22
          r_next.fsm      = pis_pkg::PIS_DONE;
          unique case (op)
            pis_pkg::CMD_RD_DATA: begin
              if (is_valve) begin
                r_next.rdata = {13'h0000, r_reg.v_chan, r_reg.v_dir, r_reg.v_busy};
              end else if (mux[9:5] == pis_pkg::MUX_CNT_PAGE) begin
                r_next.rdata = {10'h000, r_reg.cnt[mux[4:0]]}; // RQ15
                if (is_crit) begin
                  r_next.cnt[mux[4:0]] = {13'h0000, edge_v[mux[4:0]]}; // RQ4 RQ24
                end
              end else if (mux[9:5] == pis_pkg::MUX_AO_PAGE) begin
                r_next.rdata = {14'h0000, r_reg.ao[mux[4:0]]};
              end else if (mux == pis_pkg::MUX_PI_ADDR) begin
                r_next.rdata = r_reg.pi;
                if (is_crit) begin
                  r_next.pi = proc_int_in; // RQ4
                end
              end else begin
                r_next.rdata    = dig_in;
                r_next.dig_addr = mux;
              end
            end
            pis_pkg::CMD_WR_DATA: begin
              if (is_valve) begin // RQ16
                r_next.v_busy = 1'b1; // RQ10
                r_next.v_div  = 8'h00;
                r_next.v_chan = r_reg.cmd[pis_pkg::VLV_MUX_W-1:0]; // RQ7
                r_next.v_dir  = bus_data_in[pis_pkg::VD_DIR]; // RQ11 RQ25
                r_next.v_left = (bus_data_in[pis_pkg::VD_CNT_W-1:0] == 7'h00)
                              ? pis_pkg::VD_FULL
                              : {1'b0, bus_data_in[pis_pkg::VD_CNT_W-1:0]}; // RQ25
              end else if (mux[9:5] == pis_pkg::MUX_AO_PAGE) begin
                r_next.ao[mux[4:0]] = bus_data_in[pis_pkg::AO_W-1:0]; // RQ5 RQ16
              end else if (mux[9:5] != pis_pkg::MUX_CNT_PAGE && mux != pis_pkg::MUX_PI_ADDR) begin
                r_next.dig_out  = bus_data_in; // RQ16
                r_next.dig_addr = mux;
                r_next.dig_stb  = 1'b1;
              end
            end
            pis_pkg::CMD_RD_STAT: begin
              r_next.rdata = stat_word; // RQ17
            end
            pis_pkg::CMD_RD_CLR: begin
              r_next.rdata  = stat_word; // RQ18
              r_next.status = 24'h000000; // RQ18
            end
            pis_pkg::CMD_WR_STAT: begin
              if (bus_data_in[pis_pkg::MCLR_BIT]) begin // RQ20
                r_next.cnt    = '0;
                r_next.pi     = proc_int_in;
                r_next.status = 24'h000000;
                r_next.v_busy = 1'b0;
                r_next.v_left = 8'h00;
                r_next.v_div  = 8'h00;
              end else begin
                r_next.status[22:0] = bus_data_in[22:0]; // RQ19
              end
            end
            pis_pkg::CMD_RD_LEVEL: begin
              r_next.rdata = (|r_reg.pi) ? (24'h000001 << r_reg.intbit) : 24'h000000; // RQ14
            end
            default: begin
              r_next.rdata = 24'h000000;
            end
          endcase
        end
      end
      pis_pkg::PIS_DONE: begin
        if (!xfer_req) begin
          r_next.xfer_ack = 1'b0; // RQ22
          r_next.fsm      = pis_pkg::PIS_IDLE;
        end
      end
      default: begin
        r_next.fsm = pis_pkg::PIS_IDLE;
      end
    endcase

    // valve outputs follow the generator state
    r_next.v_inc = r_next.v_busy & ~r_next.v_dir; // RQ11
    r_next.v_dec = r_next.v_busy & r_next.v_dir; // RQ11

    // apb slave, one wait state
    hit = (paddr == pis_pkg::ADDR_DEVCFG) || (paddr == pis_pkg::ADDR_LEVEL)
       || (paddr == pis_pkg::ADDR_STATUS) || (paddr == pis_pkg::ADDR_VALVE);
    r_next.pready  = 1'b0;
    r_next.pslverr = 1'b0;
    if (psel && penable && !r_reg.pready) begin
      r_next.pready  = 1'b1;
      r_next.pslverr = !hit;
      r_next.prdata  = 32'h00000000;
      if (!pwrite) begin
        unique case (1'b1)
          paddr == pis_pkg::ADDR_DEVCFG:
            r_next.prdata = {8'h00, r_reg.valve, r_reg.noncrit, r_reg.crit};
          paddr == pis_pkg::ADDR_LEVEL:
            r_next.prdata = {19'h00000, r_reg.intbit, r_reg.level};
          paddr == pis_pkg::ADDR_STATUS:
            r_next.prdata = {8'h00, stat_word};
          paddr == pis_pkg::ADDR_VALVE:
            r_next.prdata = {13'h0000, r_reg.v_left, r_reg.v_chan, r_reg.v_dir, r_reg.v_busy};
          default:
            r_next.prdata = 32'h00000000;
        endcase
      end
    end
    if (psel && penable && r_reg.pready && pwrite) begin
      if (paddr == pis_pkg::ADDR_DEVCFG) begin
        r_next.crit    = pwdata[7:0];
        r_next.noncrit = pwdata[15:8];
        r_next.valve   = pwdata[23:16];
      end else if (paddr == pis_pkg::ADDR_LEVEL) begin
        r_next.level  = pwdata[7:0];
        r_next.intbit = pwdata[12:8];
      end
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg         <= '0;
      r_reg.fsm     <= pis_pkg::PIS_IDLE;
      r_reg.crit    <= pis_pkg::RST_CRIT;
      r_reg.noncrit <= pis_pkg::RST_NONCRIT;
      r_reg.valve   <= pis_pkg::RST_VALVE;
      r_reg.level   <= pis_pkg::RST_LEVEL;
      r_reg.intbit  <= pis_pkg::RST_INTBIT;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule
`default_nettype wire

// file: testbench/pis_sync_properties.sv
// assertions on the bus handshake and valve pulse outputs
`default_nettype none
module pis_sync_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        cmd_req,
  input wire logic        cmd_ack,
  input wire logic        xfer_req,
  input wire logic        xfer_ack,
  input wire logic [23:0] bus_data_out,
  input wire logic        dig_out_stb,
  input wire logic [8:0]  valve_chan,
  input wire logic        valve_inc,
  input wire logic        valve_dec
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic        pulse_on;
  logic [15:0] width_reg;
  assign pulse_on = valve_inc | valve_dec;
  // pulse length in clocks, held for one clock after the pulse ends, zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_reg <= 16'h0000;
    end else begin
      width_reg <= pulse_on ? width_reg + 16'h0001 : 16'h0000;
    end
  end
  sequence s_cmd_rise;
    !cmd_ack ##1 cmd_ack;
  endsequence
  sequence s_xfer_rise;
    !xfer_ack ##1 xfer_ack;
  endsequence
  cmd_ack_cause_a: assert property (s_cmd_rise |-> $past(cmd_req))
    else $error("command ack rose with no request");
  cmd_ack_release_a: assert property (cmd_ack && !cmd_req |=> !cmd_ack)
    else $error("command ack held after request dropped");
  xfer_ack_cause_a: assert property (s_xfer_rise |-> $past(xfer_req) && !cmd_ack)
    else $error("data ack rose out of order");
  xfer_ack_hold_a: assert property (xfer_ack && xfer_req |=> xfer_ack)
    else $error("data ack dropped while request held");
  read_word_hold_a: assert property (xfer_ack && $past(xfer_ack) |-> $stable(bus_data_out))
    else $error("read word moved during data ack");
  valve_one_dir_a: assert property (!(valve_inc && valve_dec))
    else $error("both valve outputs high");
  valve_start_a: assert property ($rose(pulse_on) |-> xfer_ack)
    else $error("valve pulse began outside a data ack");
  valve_chan_hold_a: assert property (pulse_on && $past(pulse_on) |-> $stable(valve_chan))
    else $error("valve channel moved during pulse");
  valve_width_a: assert property ($fell(pulse_on) |-> int'(width_reg) % pis_pkg::TICK_CYC == 0
      && width_reg >= pis_pkg::TICK_CYC && width_reg <= 128 * pis_pkg::TICK_CYC)
    else $error("valve pulse width not a whole tick count");
  dig_strobe_a: assert property (dig_out_stb |-> xfer_ack)
    else $error("digital strobe outside a data ack");
endmodule
bind pis_sync pis_sync_properties u_props (
  .pclk, .presetn, .cmd_req, .cmd_ack, .xfer_req, .xfer_ack, .bus_data_out,
  .dig_out_stb, .valve_chan, .valve_inc, .valve_dec
);
`default_nettype wire

// file: testbench/pis_cpu_model.sv
// processor side of the programmed_io_bus: command and data exchanges
`default_nettype none
module pis_cpu_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic [23:0] op,
  input  wire logic [23:0] wdat,
  input  wire logic        cmd_ack,
  input  wire logic        xfer_ack,
  input  wire logic [23:0] bus_data_out,
  output logic             cmd_req,
  output logic      [23:0] cmd_word,
  output logic             xfer_req,
  output logic      [23:0] bus_data_in,
  output logic      [23:0] rdat,
  output logic             done,
  output logic             fail
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 240;
  // wait for an ack level; gives up after about 12 us
  task automatic wait_ack(input logic sel, input logic lvl, output logic to);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((sel ? xfer_ack : cmd_ack) !== lvl && n < LIMIT);
    to = ((sel ? xfer_ack : cmd_ack) !== lvl);
  endtask
  initial begin
    logic to;
    cmd_req = 1'b0;
    xfer_req = 1'b0;
    cmd_word = 24'h000000;
    bus_data_in = 24'h000000;
    rdat = 24'h000000;
    done = 1'b1;
    fail = 1'b0;
    forever begin
      @(posedge pclk);
      if (go === 1'b1 && presetn === 1'b1) begin
        done <= 1'b0;
        cmd_word <= op;
        cmd_req <= 1'b1;
        wait_ack(1'b0, 1'b1, to);
        cmd_req <= 1'b0;
        cmd_word <= ~op;
        if (!to) wait_ack(1'b0, 1'b0, to);
        if (!to) begin
          xfer_req <= 1'b1;
          bus_data_in <= wdat;
          wait_ack(1'b1, 1'b1, to);
          rdat <= bus_data_out;
          xfer_req <= 1'b0;
          bus_data_in <= ~wdat;
        end
        if (!to) wait_ack(1'b1, 1'b0, to);
        fail <= to;
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the process i/o bus synchronizer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CRIT = pis_pkg::RST_CRIT;
  localparam logic [7:0] NONC = pis_pkg::RST_NONCRIT;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h00000000;
  logic [31:0]  pulse_in = 32'h00000000;
  logic [23:0]  proc_int_in = 24'h000000;
  logic [23:0]  dig_in = 24'h000000;
  logic [23:0]  op = 24'h000000;
  logic [23:0]  wdat = 24'h000000;
  logic         go = 1'b0;
  logic [31:0]  prdata, rd;
  logic         pready, pslverr, er, cmd_req, cmd_ack, xfer_req, xfer_ack, rf, done;
  logic [23:0]  cmd_word, bus_data_in, bus_data_out, rq, rdat, dig_out;
  logic         dig_out_stb, valve_inc, valve_dec;
  logic [9:0]   dig_addr;
  logic [8:0]   valve_chan;
  logic [319:0] analog_out;
  logic [8:0]   vch [3] = '{9'h005, 9'h1FF, 9'h0AA};
  logic [7:0]   vdt [3] = '{8'h02, 8'h81, 8'h00};
  int           mismatches = 0, compares = 0, cyc = 0, vcnt = 0, vlast = 0, nstb = 0;
  pis_sync uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cmd_req, .cmd_word, .cmd_ack, .xfer_req, .bus_data_in, .bus_data_out,
    .xfer_ack, .pulse_in, .proc_int_in, .dig_in, .dig_addr, .dig_out, .dig_out_stb,
    .analog_out, .valve_chan, .valve_inc, .valve_dec);
  pis_cpu_model u_cpu (.pclk, .presetn, .go, .op, .wdat, .cmd_ack, .xfer_ack,
    .bus_data_out, .cmd_req, .cmd_word, .xfer_req, .bus_data_in, .rdat, .done, .fail(rf));
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    vcnt <= (valve_inc | valve_dec) ? vcnt + 1 : 0;
    if (dig_out_stb === 1'b1) nstb <= nstb + 1;
    if (!(valve_inc | valve_dec) && vcnt != 0) vlast <= vcnt;
    if (cyc == 70000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: got %h, expected %h", $time, s, got, exp);
    end
  endtask
  task automatic chq(input logic [23:0] e, input string s);
    chk({8'h00, rq}, {8'h00, e}, s);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) chk(32'h0, 32'h1, "apb hang");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic bus_op(input logic [7:0] d, input logic [3:0] c, input logic [9:0] m,
                        input logic [23:0] w);
    int k;
    k = 0;
    op <= {d, 1'b0, c, 1'b0, m};
    wdat <= w;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do begin
      @(posedge pclk);
      k++;
    end while (done !== 1'b1 && k < 2000);
    if (done !== 1'b1) chk(32'h0, 32'h1, "bus hang");
    rq = rdat;
  endtask
  task automatic pulses(input int i, input int n);
    repeat (n) begin
      pulse_in <= 32'h00000001 << i;
      @(posedge pclk);
      pulse_in <= 32'h00000000;
      @(posedge pclk);
    end
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, pis_pkg::ADDR_DEVCFG, 32'h00000000);
    chk(rd, 32'h00030201, "devcfg");
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    chk({31'h0, er}, 32'h00000001, "unmapped");
    apb(1'b1, pis_pkg::ADDR_LEVEL, 32'h00000304);
    apb(1'b0, pis_pkg::ADDR_LEVEL, 32'h00000000);
    chk(rd, 32'h00000304, "level");
    pulses(0, 5);
    bus_op(NONC, pis_pkg::CMD_RD_DATA, 10'h000, 24'h000000);
    chq(24'h000005, "count");
    bus_op(CRIT, pis_pkg::CMD_RD_DATA, 10'h000, 24'h000000);
    chq(24'h000005, "count kept");
    bus_op(CRIT, pis_pkg::CMD_RD_DATA, 10'h000, 24'h000000);
    chq(24'h000000, "count reset");
    pulses(16, 257);
    bus_op(CRIT, pis_pkg::CMD_RD_DATA, 10'h010, 24'h000000);
    chq(24'h000001, "8-bit wrap");
    pulses(1, 16385);
    bus_op(CRIT, pis_pkg::CMD_RD_DATA, 10'h001, 24'h000000);
    chq(24'h000001, "14-bit wrap");
    bus_op(CRIT, pis_pkg::CMD_WR_DATA, 10'h021, 24'h0003FF);
    chk({22'h0, analog_out[19:10]}, 32'h000003FF, "analog hold");
    bus_op(NONC, pis_pkg::CMD_WR_DATA, 10'h022, 24'h000155);
    chk({31'h0, rf}, 32'h00000001, "noncrit write");
    chk({22'h0, analog_out[29:20]}, 32'h00000000, "analog untouched");
    bus_op(8'h55, pis_pkg::CMD_RD_DATA, 10'h000, 24'h000000);
    chk({31'h0, rf}, 32'h00000001, "other device");
    bus_op(CRIT, 4'h0, 10'h000, 24'h000000);
    chk({31'h0, rf}, 32'h00000001, "bad command");
    bus_op(NONC, pis_pkg::CMD_RD_STAT, 10'h000, 24'h000000);
    chq(24'h000002, "status");
    bus_op(CRIT, pis_pkg::CMD_RD_CLR, 10'h000, 24'h000000);
    chq(24'h000002, "status clr");
    bus_op(CRIT, pis_pkg::CMD_RD_STAT, 10'h000, 24'h000000);
    chq(24'h000000, "status cleared");
    bus_op(CRIT, pis_pkg::CMD_WR_STAT, 10'h000, 24'h000002);
    bus_op(CRIT, pis_pkg::CMD_RD_STAT, 10'h000, 24'h000000);
    chq(24'h000002, "status load");
    pulses(2, 3);
    bus_op(CRIT, pis_pkg::CMD_WR_STAT, 10'h000, 24'h800000);
    bus_op(CRIT, pis_pkg::CMD_RD_DATA, 10'h002, 24'h000000);
    chq(24'h000000, "clear count");
    bus_op(CRIT, pis_pkg::CMD_RD_STAT, 10'h000, 24'h000000);
    chq(24'h000000, "clear status");
    dig_in <= 24'hA5A5A5;
    bus_op(NONC, pis_pkg::CMD_RD_DATA, 10'h155, 24'h000000);
    chq(24'hA5A5A5, "digital read");
    chk({22'h0, dig_addr}, 32'h00000155, "digital addr");
    bus_op(CRIT, pis_pkg::CMD_WR_DATA, 10'h1FF, 24'h123456);
    chk({8'h00, dig_out}, 32'h00123456, "digital write");
    chk(nstb, 32'h00000001, "digital strobe");
    proc_int_in <= 24'h000100;
    @(posedge pclk);
    proc_int_in <= 24'h000000;
    bus_op(pis_pkg::RST_LEVEL, pis_pkg::CMD_RD_LEVEL, 10'h000, 24'h000000);
    chq(24'h000008, "level bit");
    bus_op(CRIT, pis_pkg::CMD_RD_DATA, pis_pkg::MUX_PI_ADDR, 24'h000000);
    chq(24'h000100, "interrupt latch");
    bus_op(pis_pkg::RST_LEVEL, pis_pkg::CMD_RD_LEVEL, 10'h000, 24'h000000);
    chq(24'h000000, "level clear");
    for (int i = 0; i < 3; i++) begin
      bus_op(pis_pkg::RST_VALVE, pis_pkg::CMD_WR_DATA, {1'b0, vch[i]}, {16'h0000, vdt[i]});
      chk({31'h0, rf}, 32'h00000000, "valve ack");
      chk({30'h0, valve_dec, valve_inc}, vdt[i][7] ? 32'h2 : 32'h1, "valve dir");
      chk({23'h0, valve_chan}, {23'h0, vch[i]}, "valve chan");
      repeat (21000) if (valve_inc | valve_dec) @(posedge pclk);
      @(posedge pclk);
      chk(vlast, (vdt[i][6:0] == 7'h00 ? 128 : vdt[i][6:0]) * pis_pkg::TICK_CYC, "width");
    end
    give_verdict();
  end
endmodule
`default_nettype wire
